// *** logic/dev_ctrl_params.svh ***
// constants for the device control and input readback block
`ifndef DEV_CTRL_PARAMS_SVH
`define DEV_CTRL_PARAMS_SVH

`define REG_ADDR_W          8
`define REG_DATA_W          16
`define ADDR_DEVICE_CONTROL 8'h10
`define ADDR_INPUT_LOW      8'h0B
`define ADDR_INPUT_HIGH     8'h0C
`define ADC_DATA_BASE       8'h40
`define DAC_DATA_BASE       8'h60
`define DEVICE_CONTROL_RST  16'h0000
`define INPUT_HIGH_W        4
`define PORT_COUNT          20
`define TEMP_W              12
`define THERMAL_LIMIT_DEGC  145
`define TEMP_LSB_PER_DEGC   8
`define POWER_ON_TIME_NS    1000
`define CLK_PERIOD_NS       10

`endif

// *** logic/dev_ctrl_pkg.sv ***
// types for the device control and input readback block
`default_nettype none
package dev_ctrl_pkg;

    typedef struct packed {
        logic       soft_reset;
        logic       burst_policy_select;
        logic       low_power_select;
        logic       series_resistance_cancel;
        logic       temp_conversion_time_select;
        logic [2:0] temp_monitor_enables;
        logic       thermal_shutdown_enable;
        logic       dac_reference_select;
        logic [5:0] lower_fields;
    } device_control_t;

    typedef enum logic [1:0] {
        ACC_OTHER     = 2'h0,
        ACC_ADC_READ  = 2'h1,
        ACC_DAC_WRITE = 2'h2,
        ACC_DAC_READ  = 2'h3
    } access_kind_t;

    typedef enum logic [2:0] {
        ST_RUN     = 3'b001,
        ST_LOWPWR  = 3'b010,
        ST_POWERUP = 3'b100
    } power_state_t;

endpackage : dev_ctrl_pkg
`default_nettype wire

// *** logic/burst_address_stepper.sv ***
// burst address pointer with plain and contextual stepping
`timescale 1ns/10ps
`default_nettype none
`include "dev_ctrl_params.svh"

module burst_address_stepper #(
    parameter int PORTS  = `PORT_COUNT,
    parameter int ADDR_W = `REG_ADDR_W
) (
    input  wire logic                      clk,
    input  wire logic                      rst,
    input  wire logic                      ce,
    input  wire logic                      burst_start,
    input  wire logic [ADDR_W-1:0]         start_addr,
    input  wire logic                      word_done,
    input  wire dev_ctrl_pkg::access_kind_t kind,
    input  wire logic                      policy,
    input  wire logic [PORTS-1:0]          adc_ports,
    input  wire logic [PORTS-1:0]          dac_ports,
    output logic [ADDR_W-1:0]              burst_addr
);

    if (PORTS < 1 || PORTS > 32 || ADDR_W < 8)
    begin : g_bad_params
        $error("burst_address_stepper: unsupported parameters");
    end

    logic [ADDR_W-1:0] next_burst_addr;
    logic [ADDR_W-1:0] adc_base;
    logic [ADDR_W-1:0] dac_base;
    logic [ADDR_W-1:0] offset;
    logic              in_adc;
    logic              in_dac;

    function automatic logic [4:0] next_port(input logic [4:0] cur,
                                             input logic [PORTS-1:0] mask);
        logic [4:0] found;
        logic       hit;
        int         idx;
        found = cur + 5'h01;
        hit   = 1'b0;
        for (int k = 1; k <= PORTS; k++)
        begin
            idx = (int'(cur) + k) % PORTS;
            if (!hit && mask[idx])
            begin
                found = 5'(idx);
                hit   = 1'b1;
            end
        end
        return found;
    endfunction : next_port

    ////////////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        adc_base        = ADDR_W'(`ADC_DATA_BASE);
        dac_base        = ADDR_W'(`DAC_DATA_BASE);
        in_adc          = burst_addr >= adc_base && burst_addr < adc_base + ADDR_W'(PORTS);
        in_dac          = burst_addr >= dac_base && burst_addr < dac_base + ADDR_W'(PORTS);
        offset          = '0;
        next_burst_addr = burst_addr;
        if (burst_start)
            next_burst_addr = start_addr;
        else if (word_done)
        begin
            next_burst_addr = burst_addr + ADDR_W'(1);
            if (policy && kind == dev_ctrl_pkg::ACC_ADC_READ && in_adc)
            begin
                offset          = burst_addr - adc_base;
                next_burst_addr = adc_base + ADDR_W'(next_port(offset[4:0], adc_ports));
            end
            else if (policy && kind == dev_ctrl_pkg::ACC_DAC_WRITE && in_dac)
            begin
                offset          = burst_addr - dac_base;
                next_burst_addr = dac_base + ADDR_W'(next_port(offset[4:0], dac_ports));
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            burst_addr <= '0;
        else if (ce)
            burst_addr <= next_burst_addr;
    end

endmodule : burst_address_stepper
`default_nettype wire

// *** logic/device_control_gpi_readback.sv ***
// device control register, power and reset sequencing, input level readback
//
// Notes on behaviour
// - control bit 6 picks dac reference: 0 external, 1 internal.
// - bit 7 with internal monitor on: reading above 145 degrees resets the device.
// - bits 10:8 enable internal, first external, second external monitors.
// - bit 11 selects default or extended temperature conversion time.
// - bit 12 enables series resistance cancellation.
// - bit 13 set holds all analog ports in high impedance.
// - clearing bit 13 runs the power-on sequence before normal operation.
// - burst policy 0 advances the register address by one per word.
// - burst policy 1 steps adc reads and dac writes only through configured data registers.
// - contextual stepping covers adc data reads and dac data writes only.
// - writing 1 to bit 15 soft resets like power-on; bit clears itself.
// - two read-only registers return input levels of ports 0-15 and 16-19.
// - each readback bit is 1 for a high input level, 0 for low.
`timescale 1ns/10ps
`default_nettype none
`include "dev_ctrl_params.svh"

module device_control_gpi_readback #(
    parameter int PORTS           = `PORT_COUNT,
    parameter int POWER_ON_CYCLES = (`POWER_ON_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
    input  wire logic                       clk,
    input  wire logic                       rst,
    input  wire logic                       ce,
    input  wire logic [`REG_ADDR_W-1:0]     reg_addr,
    input  wire logic                       reg_wr,
    input  wire logic [`REG_DATA_W-1:0]     reg_wdata,
    input  wire logic                       reg_rd,
    output logic [`REG_DATA_W-1:0]          reg_rdata,
    input  wire logic                       burst_start,
    input  wire logic                       word_done,
    input  wire dev_ctrl_pkg::access_kind_t access_kind,
    input  wire logic [PORTS-1:0]           adc_ports,
    input  wire logic [PORTS-1:0]           dac_ports,
    output logic [`REG_ADDR_W-1:0]          burst_addr,
    input  wire logic [PORTS-1:0]           general_input_port,
    input  wire logic [`TEMP_W-1:0]         internal_temp,
    input  wire logic                       internal_temp_valid,
    output dev_ctrl_pkg::device_control_t   control,
    output logic                            analog_hiz,
    output logic                            device_reset,
    output logic                            power_on_active
);

    if (PORTS != `PORT_COUNT || POWER_ON_CYCLES < 1 || POWER_ON_CYCLES > 65535)
    begin : g_bad_params
        $error("device_control_gpi_readback: unsupported parameters");
    end

    localparam logic signed [`TEMP_W-1:0] TRIP_LEVEL =
        `TEMP_W'(`THERMAL_LIMIT_DEGC * `TEMP_LSB_PER_DEGC);

    dev_ctrl_pkg::device_control_t next_control;
    dev_ctrl_pkg::power_state_t    state;
    dev_ctrl_pkg::power_state_t    next_state;
    logic [15:0]                   count;
    logic [15:0]                   next_count;
    logic                          thermal_trip;
    logic                          next_device_reset;
    logic [`REG_DATA_W-1:0]        next_reg_rdata;
    logic [PORTS-1:0]              sync1;
    logic [PORTS-1:0]              sync2;
    logic [PORTS-1:0]              sync3;
    logic [PORTS-1:0]              input_port_levels;
    logic [PORTS-1:0]              next_input_port_levels;

    ////////////////////////////////////////////////////////////////////////////////
    // reset causes and the control register
    always_comb
    begin
        thermal_trip = control.thermal_shutdown_enable && control.temp_monitor_enables[0]
                       && internal_temp_valid && $signed(internal_temp) > TRIP_LEVEL;
        next_device_reset = (control.soft_reset || thermal_trip) && !device_reset;
        next_control = control;
        if (device_reset)
            next_control = dev_ctrl_pkg::device_control_t'(`DEVICE_CONTROL_RST);
        else if (reg_wr && reg_addr == `ADDR_DEVICE_CONTROL)
            next_control = dev_ctrl_pkg::device_control_t'(reg_wdata);
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            control      <= dev_ctrl_pkg::device_control_t'(`DEVICE_CONTROL_RST);
            device_reset <= 1'b0;
        end
        else if (ce)
        begin
            control      <= next_control;
            device_reset <= next_device_reset;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // power state: low power hold and power-on sequence
    always_comb
    begin
        next_state = state;
        next_count = count;
        case (state)
            dev_ctrl_pkg::ST_RUN:
            begin
                if (control.low_power_select)
                    next_state = dev_ctrl_pkg::ST_LOWPWR;
            end
            dev_ctrl_pkg::ST_LOWPWR:
            begin
                if (!control.low_power_select)
                begin
                    next_state = dev_ctrl_pkg::ST_POWERUP;
                    next_count = '0;
                end
            end
            dev_ctrl_pkg::ST_POWERUP:
            begin
                next_count = count + 16'h0001;
                if (count == 16'(POWER_ON_CYCLES - 1))
                    next_state = control.low_power_select ? dev_ctrl_pkg::ST_LOWPWR
                                                          : dev_ctrl_pkg::ST_RUN;
            end
            default:
            begin
                next_state = dev_ctrl_pkg::ST_POWERUP;
                next_count = '0;
            end
        endcase
        if (device_reset)
        begin
            next_state = dev_ctrl_pkg::ST_POWERUP;
            next_count = '0;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state <= dev_ctrl_pkg::ST_POWERUP;
            count <= '0;
        end
        else if (ce)
        begin
            state <= next_state;
            count <= next_count;
        end
    end

    assign power_on_active = state == dev_ctrl_pkg::ST_POWERUP;
    assign analog_hiz      = state != dev_ctrl_pkg::ST_RUN || control.low_power_select
                             || device_reset;

    ////////////////////////////////////////////////////////////////////////////////
    // input level sampling: change accepted once second and third stages agree
    always_comb
    begin
        next_input_port_levels = input_port_levels;
        for (int i = 0; i < PORTS; i++)
        begin
            if (sync2[i] == sync3[i])
                next_input_port_levels[i] = sync3[i];
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            sync1             <= '0;
            sync2             <= '0;
            sync3             <= '0;
            input_port_levels <= '0;
        end
        else if (ce)
        begin
            sync1             <= general_input_port;
            sync2             <= sync1;
            sync3             <= sync2;
            input_port_levels <= next_input_port_levels;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // register read path
    always_comb
    begin
        next_reg_rdata = reg_rdata;
        if (reg_rd)
        begin
            case (reg_addr)
                `ADDR_DEVICE_CONTROL: next_reg_rdata = control;
                `ADDR_INPUT_LOW:      next_reg_rdata = input_port_levels[15:0];
                `ADDR_INPUT_HIGH:     next_reg_rdata = {12'h000,
                                          input_port_levels[PORTS-1:16]};
                default:              next_reg_rdata = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            reg_rdata <= '0;
        else if (ce)
            reg_rdata <= next_reg_rdata;
    end

    ////////////////////////////////////////////////////////////////////////////////
    burst_address_stepper #(
        .PORTS  (PORTS),
        .ADDR_W (`REG_ADDR_W)
    ) stepper (
        .clk         (clk),
        .rst         (rst),
        .ce          (ce),
        .burst_start (burst_start),
        .start_addr  (reg_addr),
        .word_done   (word_done),
        .kind        (access_kind),
        .policy      (control.burst_policy_select),
        .adc_ports   (adc_ports),
        .dac_ports   (dac_ports),
        .burst_addr  (burst_addr)
    );

endmodule : device_control_gpi_readback
`default_nettype wire

// *** dv/device_control_gpi_readback_assertions.sv ***
// assertions for the device control and input readback block
`timescale 1ns/10ps
`default_nettype none
`include "dev_ctrl_params.svh"
module device_control_gpi_readback_assertions #(
    parameter int PORTS           = `PORT_COUNT,
    parameter int POWER_ON_CYCLES = 100
) (
    input wire logic                       clk,
    input wire logic                       rst,
    input wire logic                       ce,
    input wire logic [`REG_ADDR_W-1:0]     reg_addr,
    input wire logic                       reg_wr,
    input wire logic [`REG_DATA_W-1:0]     reg_wdata,
    input wire logic                       reg_rd,
    input wire logic [`REG_DATA_W-1:0]     reg_rdata,
    input wire logic                       burst_start,
    input wire logic                       word_done,
    input wire dev_ctrl_pkg::access_kind_t access_kind,
    input wire logic [PORTS-1:0]           adc_ports,
    input wire logic [`REG_ADDR_W-1:0]     burst_addr,
    input wire logic [`TEMP_W-1:0]         internal_temp,
    input wire logic                       internal_temp_valid,
    input wire dev_ctrl_pkg::device_control_t control,
    input wire logic                       analog_hiz,
    input wire logic                       device_reset,
    input wire logic                       power_on_active
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst || !ce);
    int unsigned pcnt;
    int unsigned next_pcnt;
    always_comb next_pcnt = power_on_active ? pcnt + 1 : 0;
    always_ff @(posedge clk) pcnt <= rst ? 0 : next_pcnt;
    ////////////////////////////////////////////////////////////////////////////////
    sequence s_soft_wr;
        reg_wr && reg_addr == `ADDR_DEVICE_CONTROL && reg_wdata[15] && !device_reset;
    endsequence
    sequence s_soft_run;
        control.soft_reset ##1 device_reset
            ##1 (control == `DEVICE_CONTROL_RST && power_on_active && !device_reset);
    endsequence
    AST_SOFT_RESET: assert property (s_soft_wr |=> s_soft_run)
        else $error("soft reset sequence wrong");
    AST_WR_CTRL: assert property (
        reg_wr && reg_addr == `ADDR_DEVICE_CONTROL && !reg_wdata[15] && !device_reset
        && !control.soft_reset |=> control[14:6] == $past(reg_wdata[14:6]))
        else $error("control field not stored");
    AST_THERMAL: assert property (
        internal_temp_valid && $signed(internal_temp) > 1160 && control[7] && control[8]
        && !device_reset |=> device_reset ##1 (control == `DEVICE_CONTROL_RST && !device_reset))
        else $error("thermal trip missing");
    AST_LP_HIZ: assert property (control.low_power_select |-> analog_hiz)
        else $error("ports driven in low power");
    AST_RUN_DRIVE: assert property (
        !power_on_active && !control.low_power_select && !$past(control.low_power_select)
        && !device_reset |-> !analog_hiz) else $error("ports idle in run");
    AST_LP_EXIT: assert property (
        $fell(control.low_power_select) && !device_reset |-> ##[0:1] power_on_active)
        else $error("no power-up after low power");
    AST_POWERUP_LEN: assert property (pcnt <= POWER_ON_CYCLES + 1)
        else $error("power-up too long");
    AST_BURST_INC: assert property (
        word_done && !burst_start && (!control.burst_policy_select
        || access_kind inside {dev_ctrl_pkg::ACC_DAC_READ, dev_ctrl_pkg::ACC_OTHER})
        |=> burst_addr == $past(burst_addr) + 8'h01) else $error("burst step not +1");
    AST_BURST_ADC: assert property (
        word_done && !burst_start && control.burst_policy_select
        && access_kind == dev_ctrl_pkg::ACC_ADC_READ && burst_addr inside {[8'h40:8'h53]}
        && |adc_ports |=> burst_addr inside {[8'h40:8'h53]} && adc_ports[burst_addr - 8'h40])
        else $error("contextual step off port");
    AST_RD_HIGH: assert property (
        reg_rd && reg_addr == `ADDR_INPUT_HIGH |=> reg_rdata[15:4] == 12'h000)
        else $error("input high upper bits set");
endmodule : device_control_gpi_readback_assertions
bind device_control_gpi_readback device_control_gpi_readback_assertions #(.PORTS(PORTS),
    .POWER_ON_CYCLES(POWER_ON_CYCLES)) i_device_control_gpi_readback_assertions (.clk, .rst,
    .ce, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata, .burst_start, .word_done,
    .access_kind, .adc_ports, .burst_addr, .internal_temp, .internal_temp_valid, .control,
    .analog_hiz, .device_reset, .power_on_active);
`default_nettype wire

// *** dv/host_model.sv ***
// host side register and burst access model
`timescale 1ns/10ps
`default_nettype none
`include "dev_ctrl_params.svh"
module host_model (
    input  wire logic [`REG_DATA_W-1:0] reg_rdata,
    input  wire logic                   clk,
    output dev_ctrl_pkg::access_kind_t  access_kind,
    output logic [`REG_ADDR_W-1:0]      reg_addr,
    output logic [`REG_DATA_W-1:0]      reg_wdata,
    output logic                        reg_wr,
    output logic                        reg_rd,
    output logic                        burst_start,
    output logic                        word_done
);
    initial
    begin
        {reg_addr, reg_wdata, reg_wr, reg_rd, burst_start, word_done} = '0;
        access_kind = dev_ctrl_pkg::ACC_OTHER;
    end
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(negedge clk);
        {reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
        @(negedge clk);
        {reg_addr, reg_wdata, reg_wr} = {~a, ~d, 1'b0};
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(negedge clk);
        {reg_addr, reg_rd} = {a, 1'b1};
        @(negedge clk);
        {reg_addr, reg_rd} = {~a, 1'b0};
        d = reg_rdata;
    endtask : rd
    task automatic burst(input logic [7:0] a, input dev_ctrl_pkg::access_kind_t k, input int n);
        @(negedge clk);
        {reg_addr, access_kind, burst_start} = {a, k, 1'b1};
        @(negedge clk);
        {reg_addr, burst_start} = {~a, 1'b0};
        repeat (n)
        begin
            word_done = 1'b1;
            @(negedge clk);
            word_done = 1'b0;
            @(negedge clk);
        end
    endtask : burst
endmodule : host_model
`default_nettype wire

// *** dv/device_control_gpi_readback_test.sv ***
// self-checking test of the device control and input readback block
`timescale 1ns/10ps
`default_nettype none
`include "dev_ctrl_params.svh"
module device_control_gpi_readback_test;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic [7:0] reg_addr, burst_addr;
    logic [15:0] reg_wdata, reg_rdata, d;
    logic reg_wr, reg_rd, burst_start, word_done, internal_temp_valid = 1'b0;
    logic analog_hiz, device_reset, power_on_active;
    logic [19:0] adc_ports = 20'h80024;
    logic [19:0] dac_ports = 20'h00408;
    logic [19:0] general_input_port = 20'h00000;
    logic [11:0] internal_temp = 12'h000;
    dev_ctrl_pkg::access_kind_t access_kind;
    dev_ctrl_pkg::device_control_t control;
    int n_mismatch = 0;
    int n_compared = 0;
    always #5 clk = ~clk;
    device_control_gpi_readback #(.POWER_ON_CYCLES(4)) i_device_control_gpi_readback (.clk,
        .rst, .ce, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata, .burst_start,
        .word_done, .access_kind, .adc_ports, .dac_ports, .burst_addr, .general_input_port,
        .internal_temp, .internal_temp_valid, .control, .analog_hiz, .device_reset,
        .power_on_active);
    host_model i_host_model (.clk, .reg_rdata, .access_kind, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .burst_start, .word_done);
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp, input string name);
        i_host_model.rd(a, d);
        chk(name, exp, d);
    endtask : rd_chk
    task automatic burst_chk(input logic [15:0] ctl, input dev_ctrl_pkg::access_kind_t k,
        input logic [7:0] a, input int n, input logic [7:0] exp);
        i_host_model.wr(`ADDR_DEVICE_CONTROL, ctl);
        i_host_model.burst(a, k, n);
        chk("burst address", {8'h00, exp}, {8'h00, burst_addr});
    endtask : burst_chk
    task automatic results();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : results
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        #200000;
        n_mismatch++;
        results();
    end
    initial
    begin
        repeat (20) @(negedge clk);
        rst = 1'b0;
        rd_chk(`ADDR_DEVICE_CONTROL, `DEVICE_CONTROL_RST, "control reset value");
        for (int b = 6; b < 15; b++)
        begin
            i_host_model.wr(`ADDR_DEVICE_CONTROL, 16'h0001 << b);
            rd_chk(`ADDR_DEVICE_CONTROL, 16'h0001 << b, "control field");
        end
        i_host_model.wr(`ADDR_DEVICE_CONTROL, 16'h2000);
        @(negedge clk);
        chk("hiz in low power", 16'h0001, 16'(analog_hiz));
        i_host_model.wr(`ADDR_DEVICE_CONTROL, 16'h0000);
        @(negedge clk);
        chk("power-up after low power", 16'h0001, 16'(power_on_active));
        repeat (7) @(negedge clk);
        chk("ports driven again", 16'h0000, 16'(analog_hiz));
        burst_chk(16'h0000, dev_ctrl_pkg::ACC_ADC_READ, 8'h40, 3, 8'h43);
        burst_chk(16'h4000, dev_ctrl_pkg::ACC_ADC_READ, 8'h40, 4, 8'h42);
        burst_chk(16'h4000, dev_ctrl_pkg::ACC_DAC_WRITE, 8'h60, 2, 8'h6A);
        burst_chk(16'h4000, dev_ctrl_pkg::ACC_DAC_READ, 8'h60, 2, 8'h62);
        burst_chk(16'h4000, dev_ctrl_pkg::ACC_OTHER, 8'h41, 2, 8'h43);
        for (int p = 0; p < 2; p++)
        begin
            general_input_port = (p != 0) ? 20'h5A3C1 : 20'hA5C3E;
            repeat (8) @(negedge clk);
            rd_chk(`ADDR_INPUT_LOW, general_input_port[15:0], "input low");
            rd_chk(`ADDR_INPUT_HIGH, {12'h000, general_input_port[19:16]}, "input high");
        end
        ce = 1'b0;
        i_host_model.wr(`ADDR_DEVICE_CONTROL, 16'h0040);
        ce = 1'b1;
        rd_chk(`ADDR_DEVICE_CONTROL, 16'h4000, "write while frozen");
        rd_chk(8'hFF, 16'h0000, "unmapped read");
        for (int t = 0; t < 2; t++)
        begin
            i_host_model.wr(`ADDR_DEVICE_CONTROL, 16'h0180);
            internal_temp = 12'h488 + 12'(t);
            internal_temp_valid = 1'b1;
            @(negedge clk);
            internal_temp_valid = 1'b0;
            repeat (3) @(negedge clk);
            rd_chk(`ADDR_DEVICE_CONTROL, (t != 0) ? 16'h0000 : 16'h0180, "thermal");
        end
        i_host_model.wr(`ADDR_DEVICE_CONTROL, 16'h5040);
        i_host_model.wr(`ADDR_DEVICE_CONTROL, 16'h8000);
        repeat (3) @(negedge clk);
        rd_chk(`ADDR_DEVICE_CONTROL, 16'h0000, "soft reset");
        results();
    end
endmodule : device_control_gpi_readback_test
`default_nettype wire
